// File: rtl/csr_clock_reset.sv
// Local design decision: strobed register access.
`timescale 1ns/100ps
module csr_clock_reset (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// option bits and wake
	input csr_pkg::csr_option_type options,
	input wire logic wake_start,
	// register port
	input csr_pkg::csr_bus_type bus,
	output logic [7:0] rdata,
	// reset sources and pin
	input csr_pkg::csr_rst_req_type rst_req,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	// sequencer outputs and slow mode cpu clock enable
	output logic core_reset,
	output logic vector_fetch,
	output logic [15:0] vector_addr,
	output logic cpu_clk_en,
	// clock control outputs
	output csr_pkg::csr_src_type osc_source,
	output logic [7:0] trim_code,
	output logic clock_output_enable,
	output logic multiplier_lock_flag,
	output logic clk_valid
);
	import csr_pkg::*;

	typedef enum logic [1:0] {
		CSR_ACTIVE,
		CSR_DELAY,
		CSR_FETCH,
		CSR_RUN
	} csr_state_type;

	logic [7:0] main_ctrl_reg;
	logic [7:0] trim_reg;
	csr_state_type state_reg;
	csr_state_type state_next;
	logic [8:0] delay_reg;
	logic [1:0] fetch_reg;
	logic [4:0] div_reg;
	logic [12:0] start_reg;
	logic [12:0] lock_reg;
	logic pin_low_reg;
	logic pin_low_sync_reg;
	logic any_req;
	logic [1:0] oe_hist_reg;
	logic [5:0] gap_reg;

	// ---------------------------------------------------------------
	// external pin capture
	// ---------------------------------------------------------------
	// low pin latched without a clock so a halted device still resets
	always_ff @(posedge ref_clk or negedge reset_pin_in) begin
		if (!reset_pin_in) begin
			pin_low_reg <= 1'b1;
		end else begin
			pin_low_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_low_sync_reg <= 1'b1;
		end else begin
			pin_low_sync_reg <= pin_low_reg;
		end
	end

	// our own drive stays in the synchroniser for two edges after release
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			oe_hist_reg <= 2'h0;
		end else begin
			oe_hist_reg <= {oe_hist_reg[0], reset_pin_oe};
		end
	end

	// merged request, the pin only counts once our own drive has drained
	assign any_req = (pin_low_sync_reg && !reset_pin_oe && oe_hist_reg == 2'h0)
		|| rst_req.low_voltage_detector || rst_req.watchdog || rst_req.illegal_op;

	// ---------------------------------------------------------------
	// reset sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CSR_ACTIVE: begin
				if (!any_req) begin
					state_next = CSR_DELAY;
				end
			end
			CSR_DELAY: begin
				if (delay_reg == CSR_DELAY_CYCLES - 9'h1) begin
					state_next = CSR_FETCH;
				end
			end
			CSR_FETCH: begin
				if (fetch_reg == CSR_FETCH_CYCLES - 2'h1) begin
					state_next = CSR_RUN;
				end
			end
			CSR_RUN: begin
				state_next = CSR_RUN;
			end
			default: begin
				state_next = CSR_ACTIVE;
			end
		endcase
		if (any_req && state_reg != CSR_DELAY) begin
			state_next = CSR_ACTIVE;
		end
	end

	// a request in the delay restarts the count there, except in the last delay cycle, which still moves on to fetch
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= CSR_ACTIVE;
		end else begin
			state_reg <= state_next;
		end
	end

	// delay counts undivided cycles
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			delay_reg <= 9'h0;
		end else if (state_reg != CSR_DELAY || any_req) begin
			delay_reg <= 9'h0;
		end else begin
			delay_reg <= delay_reg + 9'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fetch_reg <= 2'h0;
		end else if (state_reg == CSR_FETCH) begin
			fetch_reg <= fetch_reg + 2'h1;
		end else begin
			fetch_reg <= 2'h0;
		end
	end

	// outputs of the sequencer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			core_reset <= 1'b1;
			vector_fetch <= 1'b0;
			vector_addr <= CSR_VECTOR_ADDR;
			reset_pin_out <= 1'b0;
			reset_pin_oe <= 1'b0;
		end else begin
			core_reset <= state_next != CSR_RUN;
			vector_fetch <= state_next == CSR_FETCH;
			vector_addr <= CSR_VECTOR_ADDR;
			reset_pin_out <= 1'b0;
			reset_pin_oe <= state_next == CSR_DELAY;
		end
	end

	// ---------------------------------------------------------------
	// clock source, multiplier startup and lock
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			osc_source <= CSR_SRC_EXT;
		end else if (options.mult_enable) begin
			osc_source <= options.mult_by8 ? CSR_SRC_PLL8 : CSR_SRC_PLL4;
		end else if (options.rc_enable) begin
			osc_source <= CSR_SRC_RC;
		end else begin
			osc_source <= CSR_SRC_EXT;
		end
	end

	// startup and lock timers restart on reset or wakeup
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			start_reg <= 13'h0;
			lock_reg <= 13'h0;
		end else if (core_reset || wake_start || !options.mult_enable) begin
			start_reg <= 13'h0;
			lock_reg <= 13'h0;
		end else if (start_reg != 13'(CSR_STARTUP_CYCLES)) begin
			start_reg <= start_reg + 13'h1;
		end else if (lock_reg != 13'(CSR_LOCK_CYCLES)) begin
			lock_reg <= lock_reg + 13'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clk_valid <= 1'b0;
			multiplier_lock_flag <= 1'b0;
		end else begin
			clk_valid <= !options.mult_enable
				|| (start_reg == 13'(CSR_STARTUP_CYCLES) && !wake_start);
			multiplier_lock_flag <= options.mult_enable && !wake_start
				&& lock_reg == 13'(CSR_LOCK_CYCLES);
		end
	end

	// ---------------------------------------------------------------
	// slow mode divider
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_reg <= 5'h0;
			cpu_clk_en <= 1'b0;
		end else begin
			div_reg <= div_reg + 5'h1;
			if (main_ctrl_reg[CSR_SLOW_BIT]) begin
				cpu_clk_en <= div_reg == CSR_SLOW_DIV_LAST;
			end else begin
				cpu_clk_en <= 1'b1;
			end
		end
	end

	// cycles since the last cpu enable pulse, watched by the slow gap check
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gap_reg <= 6'h0;
		end else if (cpu_clk_en) begin
			gap_reg <= 6'h0;
		end else if (gap_reg != 6'h3f) begin
			gap_reg <= gap_reg + 6'h1;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// both registers return to defaults on every device reset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			main_ctrl_reg <= CSR_MAIN_CTRL_RESET;
			trim_reg <= CSR_TRIM_RESET;
		end else if (core_reset) begin
			main_ctrl_reg <= CSR_MAIN_CTRL_RESET;
			trim_reg <= CSR_TRIM_RESET;
		end else if (bus.wr) begin
			if (bus.addr == CSR_MAIN_CTRL_ADDR) begin
				main_ctrl_reg <= {6'h0, bus.wdata[1:0]};
			end
			if (bus.addr == CSR_TRIM_ADDR) begin
				trim_reg <= bus.wdata;
			end
		end
	end

	// trim and pin gate outputs, higher code means slower oscillator
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			trim_code <= CSR_TRIM_RESET;
			clock_output_enable <= 1'b0;
		end else begin
			trim_code <= trim_reg;
			clock_output_enable <= main_ctrl_reg[CSR_CLKOUT_BIT];
		end
	end

	// read data one cycle after the strobe, unmapped reads zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h0;
		end else if (bus.rd) begin
			case (bus.addr)
				CSR_MAIN_CTRL_ADDR: rdata <= main_ctrl_reg;
				CSR_TRIM_ADDR: rdata <= trim_reg;
				CSR_STATUS_ADDR: rdata <= {7'h0, multiplier_lock_flag};
				default: rdata <= 8'h0;
			endcase
		end else begin
			rdata <= 8'h0;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	trim_default_a: assert property (@(posedge ref_clk) disable iff (rst)
		core_reset |=> trim_reg == CSR_TRIM_RESET) else $error("trim not restored");
	src_pick_a: assert property (@(posedge ref_clk) disable iff (rst)
		(!options.mult_enable && !options.rc_enable) |=> osc_source == CSR_SRC_EXT)
		else $error("wrong source");
	pin_low_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_reg == CSR_DELAY |-> reset_pin_oe && !reset_pin_out)
		else $error("pin not driven low");
	delay_len_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_reg == CSR_DELAY && delay_reg == 9'h0 && !any_req) |->
		!(state_reg == CSR_FETCH) [*8]) else $error("delay too short");
	fetch_len_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(vector_fetch) |=> vector_fetch ##1 !vector_fetch)
		else $error("fetch not two cycles");
	slow_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
		(cpu_clk_en && main_ctrl_reg[CSR_SLOW_BIT] && $stable(main_ctrl_reg)) |=>
		!cpu_clk_en) else $error("slow enable too often");
	restart_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_reg == CSR_DELAY && any_req) |=> delay_reg == 9'h0)
		else $error("delay not restarted");
	lock_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
		multiplier_lock_flag |-> options.mult_enable && $past(clk_valid))
		else $error("lock before startup");
	clkout_a: assert property (@(posedge ref_clk) disable iff (rst)
		core_reset |=> ##1 !clock_output_enable) else $error("clock out not cleared");

	// ---------------------------------------------------------------
	// sequencer checks
	// ---------------------------------------------------------------
	delay_end_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_reg == CSR_FETCH && $past(state_reg) == CSR_DELAY) |->
		$past(delay_reg) == CSR_DELAY_CYCLES - 9'h1) else $error("delay not full length");
	core_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_reg == CSR_DELAY |-> core_reset) else $error("core released in delay");
	pin_only_a: assert property (@(posedge ref_clk) disable iff (rst)
		reset_pin_oe |-> state_reg == CSR_DELAY) else $error("pin driven outside delay");
	vec_fixed_a: assert property (@(posedge ref_clk) disable iff (rst)
		vector_fetch |-> core_reset && vector_addr == CSR_VECTOR_ADDR)
		else $error("bad vector fetch");
	req_taken_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_reg == CSR_RUN && any_req) |=> core_reset && state_reg == CSR_ACTIVE)
		else $error("request ignored");
	// the pin is latched even without a clock edge
	pin_seen_a: assert property (@(posedge ref_clk) disable iff (rst)
		!reset_pin_in |-> pin_low_reg) else $error("pin low not latched");

	// ---------------------------------------------------------------
	// clock control checks
	// ---------------------------------------------------------------
	// multiplier factor follows the option bits
	src_mult_a: assert property (@(posedge ref_clk) disable iff (rst)
		options.mult_enable |=>
		osc_source == ($past(options.mult_by8) ? CSR_SRC_PLL8 : CSR_SRC_PLL4))
		else $error("wrong multiplier factor");
	src_rc_a: assert property (@(posedge ref_clk) disable iff (rst)
		(!options.mult_enable && options.rc_enable) |=> osc_source == CSR_SRC_RC)
		else $error("rc source not chosen");
	wake_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		(wake_start && options.mult_enable) |=> !clk_valid && !multiplier_lock_flag)
		else $error("clock not withheld on wake");
	lock_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		!options.mult_enable |=> !multiplier_lock_flag) else $error("lock without multiplier");
	trim_out_a: assert property (@(posedge ref_clk) disable iff (rst)
		trim_code == $past(trim_reg)) else $error("trim code not passed on");
	clkout_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		clock_output_enable == $past(main_ctrl_reg[CSR_CLKOUT_BIT]))
		else $error("clock out gate wrong");
	reserved_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		main_ctrl_reg[7:2] == 6'h0) else $error("reserved control bits set");
	ctrl_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		core_reset |=> main_ctrl_reg == CSR_MAIN_CTRL_RESET)
		else $error("control not cleared");
	// the slow enable must come at least once in every 32 cycles
	slow_gap_a: assert property (@(posedge ref_clk) disable iff (rst)
		main_ctrl_reg[CSR_SLOW_BIT] |-> gap_reg <= {1'b0, CSR_SLOW_DIV_LAST})
		else $error("slow enable too rare");

	// ---------------------------------------------------------------
	// cover points
	// ---------------------------------------------------------------
	seq_run_c: cover property (@(posedge ref_clk) disable iff (rst)
		$fell(core_reset));
	restart_c: cover property (@(posedge ref_clk) disable iff (rst)
		state_reg == CSR_DELAY && any_req);
	lock_c: cover property (@(posedge ref_clk) disable iff (rst)
		$rose(multiplier_lock_flag));
	slow_c: cover property (@(posedge ref_clk) disable iff (rst)
		cpu_clk_en && main_ctrl_reg[CSR_SLOW_BIT]);
	wake_c: cover property (@(posedge ref_clk) disable iff (rst)
		wake_start && options.mult_enable);
endmodule

// File: rtl/csr_pkg.sv
package csr_pkg;
	localparam logic [7:0] CSR_MAIN_CTRL_ADDR = 8'h38;
	localparam logic [7:0] CSR_TRIM_ADDR = 8'h39;
	localparam logic [7:0] CSR_STATUS_ADDR = 8'h3a;
	localparam logic [7:0] CSR_MAIN_CTRL_RESET = 8'h00;
	localparam logic [7:0] CSR_TRIM_RESET = 8'hff;
	localparam int CSR_SLOW_BIT = 0;
	localparam int CSR_CLKOUT_BIT = 1;
	localparam int CSR_LOCK_BIT = 0;
	localparam logic [8:0] CSR_DELAY_CYCLES = 9'h100;
	localparam logic [1:0] CSR_FETCH_CYCLES = 2'h2;
	localparam logic [15:0] CSR_VECTOR_ADDR = 16'hfffe;
	localparam logic [4:0] CSR_SLOW_DIV_LAST = 5'h1f;
	localparam int CSR_CLK_MHZ = 40;
	localparam int CSR_STARTUP_US = 128;
	localparam int CSR_STARTUP_CYCLES = CSR_STARTUP_US * CSR_CLK_MHZ;
	localparam int CSR_LOCK_US = 64;
	localparam int CSR_LOCK_CYCLES = CSR_LOCK_US * CSR_CLK_MHZ;

	typedef enum logic [1:0] {
		CSR_SRC_EXT,
		CSR_SRC_RC,
		CSR_SRC_PLL4,
		CSR_SRC_PLL8
	} csr_src_type;

	typedef struct packed {
		logic rc_enable;
		logic mult_enable;
		logic mult_by8;
	} csr_option_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} csr_bus_type;

	typedef struct packed {
		logic low_voltage_detector;
		logic watchdog;
		logic illegal_op;
	} csr_rst_req_type;
endpackage

// File: tb/csr_reset_partner.sv
`timescale 1ns/100ps
module csr_reset_partner (
	// command from the bench
	input wire logic pull_low,
	// device side of the pin
	input wire logic dut_oe,
	input wire logic dut_out,
	// resolved pin level
	output logic pin_level
);
	// ------------------------------------------------
	// open-drain wire: weak pull-up, low when any party drives
	// ------------------------------------------------
	assign pin_level = (pull_low || (dut_oe && !dut_out)) ? 1'b0 : 1'b1;
endmodule

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import csr_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b0;
	logic wake_start = 1'b0;
	logic pull_low = 1'b0;
	logic pin_level;
	csr_option_type options = '{rc_enable: 1'b1, mult_enable: 1'b0, mult_by8: 1'b0};
	csr_bus_type bus = '0;
	csr_rst_req_type rst_req = '0;
	logic [7:0] rdata, trim_code;
	logic reset_pin_out, reset_pin_oe, core_reset, vector_fetch, cpu_clk_en;
	logic clock_output_enable, multiplier_lock_flag, clk_valid;
	logic [15:0] vector_addr;
	csr_src_type osc_source;
	int fails = 0;
	int n_tests = 0;
	logic [7:0] d;
	int n;

	// clock and design
	always #12.5 ref_clk = ~ref_clk;
	csr_clock_reset dut_u (.ref_clk(ref_clk), .rst(rst), .options(options),
		.wake_start(wake_start), .bus(bus), .rdata(rdata), .rst_req(rst_req),
		.reset_pin_in(pin_level), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
		.core_reset(core_reset), .vector_fetch(vector_fetch), .vector_addr(vector_addr),
		.cpu_clk_en(cpu_clk_en), .osc_source(osc_source), .trim_code(trim_code),
		.clock_output_enable(clock_output_enable),
		.multiplier_lock_flag(multiplier_lock_flag), .clk_valid(clk_valid));
	csr_reset_partner partner_u (.pull_low(pull_low), .dut_oe(reset_pin_oe),
		.dut_out(reset_pin_out), .pin_level(pin_level));

	// ------------------------------------------------
	// compare, bus and wait helpers
	// ------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus <= '0;
		#1 v = rdata;
	endtask
	// waits until core reset ends, counting pin drive and fetch cycles
	task automatic seq_run(output int oe_n, output int vf_n);
		oe_n = 0;
		vf_n = 0;
		for (int i = 0; i < 2000 && (oe_n == 0 || core_reset !== 1'b0); i++) begin
			@(posedge ref_clk);
			#1;
			if (reset_pin_oe === 1'b1) oe_n++;
			if (vector_fetch === 1'b1) begin
				vf_n++;
				chk(vector_addr, CSR_VECTOR_ADDR, "vector address");
			end
		end
		chk(oe_n > 0 && core_reset === 1'b0, 1'b1, "sequence finished");
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// watchdog against hangs
	initial begin
		repeat (60000) @(posedge ref_clk);
		fails++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		report_and_stop();
	end

	// ------------------------------------------------
	// test sequence
	// ------------------------------------------------
	initial begin
		int oe_n, vf_n;
		rst <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		wr(CSR_TRIM_ADDR, 8'h12);
		rd(CSR_TRIM_ADDR, d);
		chk(d, 8'hff, "write during core reset");
		seq_run(oe_n, vf_n);
		chk(osc_source, CSR_SRC_RC, "rc source");
		$display("test power-up done");
		// registers: trim, control bits, reserved bits, unmapped place
		wr(CSR_TRIM_ADDR, 8'h80);
		@(posedge ref_clk);
		#1 chk(trim_code, 8'h80, "trim output");
		wr(CSR_MAIN_CTRL_ADDR, 8'hff);
		rd(CSR_MAIN_CTRL_ADDR, d);
		chk(d, 8'h03, "control reserved bits");
		chk(clock_output_enable, 1'b1, "clock out");
		n = 0;
		repeat (64) begin
			@(posedge ref_clk);
			#1 n += (cpu_clk_en === 1'b1);
		end
		chk(n, 2, "slow mode pulses");
		rd(8'h50, d);
		chk(d, 8'h00, "unmapped read");
		$display("test registers done");
		// every reset source, pin held low by the partner for the last
		for (int k = 0; k < 4; k++) begin
			wr(CSR_TRIM_ADDR, 8'h5a);
			wr(CSR_MAIN_CTRL_ADDR, 8'h03);
			if (k == 1) options <= '{rc_enable: 1'b0, mult_enable: 1'b0, mult_by8: 1'b0};
			if (k < 3) rst_req <= csr_rst_req_type'(3'(1 << k));
			else pull_low <= 1'b1;
			repeat (4) @(posedge ref_clk);
			rst_req <= '0;
			pull_low <= 1'b0;
			seq_run(oe_n, vf_n);
			chk(oe_n, 256, "delay phase length");
			chk(vf_n, 2, "fetch length");
			rd(CSR_TRIM_ADDR, d);
			chk(d, 8'hff, "trim after reset");
			rd(CSR_MAIN_CTRL_ADDR, d);
			chk(d, 8'h00, "control after reset");
		end
		chk(osc_source, CSR_SRC_EXT, "external source");
		$display("test reset sources done");
		// a new request in mid-delay restarts the count
		@(posedge ref_clk);
		rst_req <= '{low_voltage_detector: 1'b1, watchdog: 1'b0, illegal_op: 1'b0};
		repeat (3) @(posedge ref_clk);
		rst_req <= '0;
		repeat (100) @(posedge ref_clk);
		rst_req <= '{low_voltage_detector: 1'b0, watchdog: 1'b1, illegal_op: 1'b0};
		repeat (2) @(posedge ref_clk);
		rst_req <= '0;
		repeat (250) @(posedge ref_clk);
		#1 chk(core_reset, 1'b1, "restart of delay");
		seq_run(oe_n, vf_n);
		$display("test restart done");
		// multiplier by four then by eight, startup and lock
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk);
			options <= '{rc_enable: 1'b1, mult_enable: 1'b1, mult_by8: k[0]};
			if (k == 0) begin
				rst <= 1'b1;
				repeat (6) @(posedge ref_clk);
				rst <= 1'b0;
				seq_run(oe_n, vf_n);
			end else begin
				wake_start <= 1'b1;
				@(posedge ref_clk);
				wake_start <= 1'b0;
				repeat (3) @(posedge ref_clk);
			end
			#1 chk(clk_valid, 1'b0, "clock withheld");
			chk(osc_source, k ? CSR_SRC_PLL8 : CSR_SRC_PLL4, "multiplier source");
			n = 0;
			while (clk_valid !== 1'b1 && n < 6000) begin
				@(posedge ref_clk);
				#1 n++;
			end
			chk(clk_valid, 1'b1, "clock after startup");
			n = 0;
			while (multiplier_lock_flag !== 1'b1 && n < 3000) begin
				@(posedge ref_clk);
				#1 n++;
			end
			rd(CSR_STATUS_ADDR, d);
			chk(d[CSR_LOCK_BIT], 1'b1, "lock flag");
		end
		$display("test multiplier done");
		report_and_stop();
	end
endmodule
